// [sbs_defines.svh]
`ifndef SBS_DEFINES_SVH
`define SBS_DEFINES_SVH

// Number of SDRAM blocks (A to H)
`define SBS_NUM_BLOCKS 8
// Width of a size code
`define SBS_SIZE_W 4
// Width of a processor-bus address
`define SBS_ADDR_W 32
// Reset value of every block's size code
`define SBS_SIZE_RST 4'h0
// Block size codes
`define SBS_SZ_NONE 4'h0
`define SBS_SZ_32M_X16 4'h1
`define SBS_SZ_64M_X8 4'h2
`define SBS_SZ_64M_X16 4'h3
`define SBS_SZ_128M_X4 4'h4
`define SBS_SZ_128M_X8 4'h5
`define SBS_SZ_128M_X16 4'h6
`define SBS_SZ_256M_X4 4'h7
`define SBS_SZ_256M_X8 4'h8
`define SBS_SZ_512M_X4 4'h9
// Bank count that is supported, and bytes per location
`define SBS_BANKS_OK 8'h04
`define SBS_LOC_BYTES 8
// Capacity masks (capacity minus one) per size
`define SBS_MASK_32M 32'h01FF_FFFF
`define SBS_MASK_64M 32'h03FF_FFFF
`define SBS_MASK_128M 32'h07FF_FFFF
`define SBS_MASK_256M 32'h0FFF_FFFF
`define SBS_MASK_512M 32'h1FFF_FFFF

`endif

// [sbs_pkg.sv]
`include "sbs_defines.svh"

package sbs_pkg;
    // Row/column split used by the address translator
    typedef enum logic [2:0] {
        SBS_MAP_NONE = 3'h0,
        SBS_MAP_C8 = 3'h1,
        SBS_MAP_C9 = 3'h3,
        SBS_MAP_C10 = 3'h2,
        SBS_MAP_C11 = 3'h6
    } sbs_map_t;

    // All registered state of the block
    typedef struct packed {
        logic [`SBS_NUM_BLOCKS-1:0][`SBS_SIZE_W-1:0] size;
        logic [`SBS_NUM_BLOCKS-1:0] enable;
        logic hit;
        logic [2:0] blk;
        logic [`SBS_ADDR_W-1:0] off;
        logic [`SBS_NUM_BLOCKS-1:0] scrub_incl;
    } sbs_state_t;
endpackage

// [sbs_block_sizing.sv]
`timescale 1ns/10ps
`include "sbs_defines.svh"

// Overview of operation
// RQ1: Software loads timing fields from the slowest present block in bus clocks.
// RQ2: Software computes locations as two to rows times two to columns times banks.
// RQ3: A block whose bank count is not four can never be enabled; the code checks the count only on cfg_wr_in and enable then holds.
// RQ4: Size codes one to nine decode to 32MB through 512MB geometries.
// RQ5: Block capacity equals locations times eight bytes.
// RQ6: Software picks the size code from locations and device width.
// RQ7: Software waits at least one refresh before rewriting SDRAM control.
// RQ8: Software keeps refresh_inhibit clear during the refresh wait.
// RQ9: Software sets write and data precharge options to one.
// RQ10: Software aligns each base to a multiple of the block capacity.
// RQ11: Software enables and sizes only populated blocks.
// RQ12: Software waits one refresh after sizing before first access.
// RQ13: Before probing, software sets the error bits to their probe state.
// RQ14: Before probing, software clears the legacy gap and frees low space.
// RQ15: Probing places one block alone at base zero, starting at 512MB.
// RQ16: Probing writes and reads patterns, stepping down on mismatch.
// RQ17: Each trial size has its own list of probe addresses.
// RQ18: A block that never matches gets size code zero.
// RQ19: The 16Mx8/16Mx4 and 8Mx16/8Mx8 codes behave identically.
// RQ20: Speed settings hold reset or real values before probing.
// RQ21: Size codes reset to zero and drive decoding and translation.
// RQ22: Scrubbing includes a block only when its size code is non-zero.
// RQ23: An access is claimed only when enabled and inside base plus capacity.

module sbs_block_sizing
    import sbs_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Block configuration written by software
    input wire logic [`SBS_NUM_BLOCKS-1:0] cfg_wr_in,
    input wire logic [`SBS_SIZE_W-1:0] cfg_size_in,
    input wire logic cfg_enable_in,
    input wire logic [`SBS_NUM_BLOCKS-1:0][`SBS_ADDR_W-1:0] base_in,
    input wire logic [`SBS_NUM_BLOCKS-1:0][7:0] bank_count_in,
    input wire logic scrub_enable_in,
    // Bus access to decode
    input wire logic [`SBS_ADDR_W-1:0] addr_in,
    // Status and decode results
    output logic [`SBS_NUM_BLOCKS-1:0][`SBS_SIZE_W-1:0] size_out,
    output logic [`SBS_NUM_BLOCKS-1:0] enable_out,
    output logic [`SBS_NUM_BLOCKS-1:0] scrub_incl_out,
    output logic hit_out,
    output logic [2:0] hit_block_out,
    output logic [`SBS_ADDR_W-1:0] offset_out,
    output logic [`SBS_ADDR_W-1:0] row_out,
    output logic [`SBS_ADDR_W-1:0] col_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Size decode helpers

    // Capacity minus one for a size code; zero code gives no window
    function automatic logic [`SBS_ADDR_W-1:0] cap_mask(input logic [`SBS_SIZE_W-1:0] c);
        logic [`SBS_ADDR_W-1:0] m;
        m = '0;
        unique case (c)
            `SBS_SZ_32M_X16: m = `SBS_MASK_32M; // [RQ4] [RQ5]
            `SBS_SZ_64M_X8, `SBS_SZ_64M_X16: m = `SBS_MASK_64M; // [RQ4] [RQ19]
            `SBS_SZ_128M_X4, `SBS_SZ_128M_X8, `SBS_SZ_128M_X16: m = `SBS_MASK_128M; // [RQ4]
            `SBS_SZ_256M_X4, `SBS_SZ_256M_X8: m = `SBS_MASK_256M; // [RQ4]
            `SBS_SZ_512M_X4: m = `SBS_MASK_512M; // [RQ4]
            default: m = '0;
        endcase
        return m;
    endfunction

    // Column width per code; both codes of each equivalent pair share one mapping
    function automatic sbs_map_t col_map(input logic [`SBS_SIZE_W-1:0] c);
        sbs_map_t r;
        r = SBS_MAP_NONE;
        unique case (c)
            `SBS_SZ_32M_X16, `SBS_SZ_128M_X16: r = SBS_MAP_C8;
            `SBS_SZ_64M_X8, `SBS_SZ_64M_X16: r = SBS_MAP_C9; // [RQ19]
            `SBS_SZ_128M_X8, `SBS_SZ_128M_X4: r = SBS_MAP_C9; // [RQ19]
            `SBS_SZ_256M_X8, `SBS_SZ_256M_X4: r = SBS_MAP_C10;
            `SBS_SZ_512M_X4: r = SBS_MAP_C11;
            default: r = SBS_MAP_NONE;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    sbs_state_t state_q;
    sbs_state_t state_d;
    logic [`SBS_NUM_BLOCKS-1:0] in_win;
    logic [`SBS_NUM_BLOCKS-1:0][`SBS_ADDR_W-1:0] win_off;

    // Per-block window compare
    genvar gi;
    generate
        for (gi = 0; gi < `SBS_NUM_BLOCKS; gi++) begin : g_win
            logic [`SBS_ADDR_W-1:0] m;
            assign m = cap_mask(state_q.size[gi]);
            assign win_off[gi] = addr_in - base_in[gi];
            // Claimed only inside base..base+capacity when enabled; codes without a
            // capacity (zero, or above nine) never claim, not even the base address
            assign in_win[gi] = state_q.enable[gi] && (m != '0)
                && (addr_in >= base_in[gi]) && ((win_off[gi] & ~m) == '0); // [RQ23] [RQ21]
        end
    endgenerate

    // Next-state logic
    always_comb begin
        state_d = state_q;
        for (int i = 0; i < `SBS_NUM_BLOCKS; i++) begin
            if (cfg_wr_in[i]) begin
                state_d.size[i] = cfg_size_in;
                // Only four-bank parts may be switched on
                state_d.enable[i] = cfg_enable_in && (bank_count_in[i] == `SBS_BANKS_OK); // [RQ3]
            end
            state_d.scrub_incl[i] = scrub_enable_in && (state_d.size[i] != `SBS_SZ_NONE); // [RQ22]
        end
        state_d.hit = 1'b0;
        state_d.blk = 3'h0;
        state_d.off = '0;
        for (int i = `SBS_NUM_BLOCKS - 1; i >= 0; i--) begin
            if (in_win[i]) begin
                state_d.hit = 1'b1; // [RQ23]
                state_d.blk = 3'(i);
                state_d.off = win_off[i];
            end
        end
    end

    // State register; size codes clear at reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= '0; // [RQ21]
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Row and column split of the registered offset by size code
    sbs_map_t hit_map;
    logic [`SBS_ADDR_W-1:0] word_off;
    assign hit_map = col_map(state_q.size[state_q.blk]);
    assign word_off = state_q.off >> $clog2(`SBS_LOC_BYTES); // [RQ5]
    always_comb begin
        row_out = '0;
        col_out = '0;
        unique case (hit_map)
            SBS_MAP_C8: begin
                row_out = word_off >> 8; // [RQ21]
                col_out = word_off & 32'h0000_00FF;
            end
            SBS_MAP_C9: begin
                row_out = word_off >> 9;
                col_out = word_off & 32'h0000_01FF;
            end
            SBS_MAP_C10: begin
                row_out = word_off >> 10;
                col_out = word_off & 32'h0000_03FF;
            end
            SBS_MAP_C11: begin
                row_out = word_off >> 11;
                col_out = word_off & 32'h0000_07FF;
            end
            default: begin
                row_out = '0;
                col_out = '0;
            end
        endcase
        if (!state_q.hit) begin
            row_out = '0;
            col_out = '0;
        end
    end

    assign size_out = state_q.size;
    assign enable_out = state_q.enable;
    assign scrub_incl_out = state_q.scrub_incl;
    assign hit_out = state_q.hit;
    assign hit_block_out = state_q.blk;
    assign offset_out = state_q.off;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_size_reset;
        @(posedge clk_in) rst_in |=> (size_out == '0) && (enable_out == '0);
    endproperty
    a_size_reset: assert property (p_size_reset) else $error("size not cleared by reset"); // [RQ21]

    property p_cfg_store;
        @(posedge clk_in) disable iff (rst_in)
        cfg_wr_in[1] |=> size_out[1] == $past(cfg_size_in);
    endproperty
    a_cfg_store: assert property (p_cfg_store) else $error("size code not stored"); // [RQ21]

    property p_scrub;
        @(posedge clk_in) disable iff (rst_in)
        scrub_incl_out[2] |-> size_out[2] != `SBS_SZ_NONE;
    endproperty
    a_scrub: assert property (p_scrub) else $error("unsized block scrubbed"); // [RQ22]

    // Per-block bank gate and claim checks; the block index is fixed per copy so
    // that the previous cycle's enable and size belong to the block that hit
    genvar gj;
    generate
        for (gj = 0; gj < `SBS_NUM_BLOCKS; gj++) begin : g_chk
            property p_bank_gate;
                @(posedge clk_in) disable iff (rst_in)
                (cfg_wr_in[gj] && bank_count_in[gj] != `SBS_BANKS_OK) |=> !enable_out[gj];
            endproperty
            a_bank_gate: assert property (p_bank_gate) // [RQ3]
                else $error("non-four-bank block enabled");

            property p_hit_needs_enable;
                @(posedge clk_in) disable iff (rst_in)
                (hit_out && hit_block_out == 3'(gj)) |-> $past(enable_out[gj]);
            endproperty
            a_hit_needs_enable: assert property (p_hit_needs_enable) // [RQ23]
                else $error("hit on disabled block");

            property p_hit_in_range;
                @(posedge clk_in) disable iff (rst_in)
                (hit_out && hit_block_out == 3'(gj))
                |-> (offset_out & ~cap_mask($past(size_out[gj]))) == '0;
            endproperty
            a_hit_in_range: assert property (p_hit_in_range) // [RQ23] [RQ5]
                else $error("hit outside capacity");

            c_refuse: cover property (@(posedge clk_in) disable iff (rst_in)
                cfg_wr_in[gj] && cfg_enable_in && bank_count_in[gj] != `SBS_BANKS_OK);
        end
    endgenerate

    property p_512m_cap;
        @(posedge clk_in) disable iff (rst_in)
        (enable_out[0] && size_out[0] == `SBS_SZ_512M_X4 && base_in[0] == '0
            && addr_in == 32'h1FFF_FFF8 && enable_out[7:1] == '0 && !cfg_wr_in[0]) |=> hit_out;
    endproperty
    a_512m_cap: assert property (p_512m_cap) else $error("512MB top word not claimed"); // [RQ4]

    property p_32m_limit;
        @(posedge clk_in) disable iff (rst_in)
        (size_out[0] == `SBS_SZ_32M_X16 && base_in[0] == '0 && addr_in == 32'h0200_0000
            && enable_out[7:1] == '0 && !cfg_wr_in[0]) |=> !hit_out;
    endproperty
    a_32m_limit: assert property (p_32m_limit) else $error("32MB block claims beyond capacity"); // [RQ4]

    property p_pair_same;
        @(posedge clk_in) disable iff (rst_in)
        (hit_out && (size_out[hit_block_out] inside {`SBS_SZ_64M_X8, `SBS_SZ_64M_X16,
            `SBS_SZ_128M_X4, `SBS_SZ_128M_X8}))
            |-> (col_out == ((offset_out >> 3) & 32'h0000_01FF))
            && (row_out == (offset_out >> 12));
    endproperty
    a_pair_same: assert property (p_pair_same) else $error("paired codes map differently"); // [RQ19]

    c_hit: cover property (@(posedge clk_in) disable iff (rst_in) hit_out);
    c_scrub: cover property (@(posedge clk_in) disable iff (rst_in) scrub_incl_out != '0);

endmodule

// [sbs_spd_model.sv]
`timescale 1ns/10ps
`include "sbs_defines.svh"

// Presence data of the eight SDRAM blocks: the bank count that each one reports
module sbs_spd_model
    import sbs_pkg::*;
#(
    parameter logic [7:0] ODD_BANKS = 8'h02
)
(
    // Block whose presence data reports an unsupported bank count
    input wire logic [2:0] odd_block_in,
    // Bank count per block
    output logic [`SBS_NUM_BLOCKS-1:0][7:0] bank_count_out,
    // Row address bits, column address bits and primary device width per block
    output logic [`SBS_NUM_BLOCKS-1:0][7:0] row_bits_out,
    output logic [`SBS_NUM_BLOCKS-1:0][7:0] col_bits_out,
    output logic [`SBS_NUM_BLOCKS-1:0][7:0] width_out
);
    // One device geometry per block, spanning the size codes from 32MB to 512MB
    localparam logic [`SBS_NUM_BLOCKS-1:0][7:0] ROW_BITS =
        {8'h0D, 8'h0D, 8'h0D, 8'h0D, 8'h0C, 8'h0D, 8'h0C, 8'h0C};
    localparam logic [`SBS_NUM_BLOCKS-1:0][7:0] COL_BITS =
        {8'h0B, 8'h0A, 8'h0A, 8'h09, 8'h0A, 8'h08, 8'h09, 8'h08};
    localparam logic [`SBS_NUM_BLOCKS-1:0][7:0] DEV_WIDTH =
        {8'h04, 8'h08, 8'h04, 8'h08, 8'h04, 8'h10, 8'h08, 8'h10};

    // Geometry bytes as the presence data reports them
    assign row_bits_out = ROW_BITS;
    assign col_bits_out = COL_BITS;
    assign width_out = DEV_WIDTH;

    // Every block reports four banks except the odd one
    always_comb begin
        for (int i = 0; i < `SBS_NUM_BLOCKS; i++) begin
            bank_count_out[i] = (3'(i) == odd_block_in) ? ODD_BANKS : 8'h04;
        end
    end
endmodule

// [tb.sv]
`timescale 1ns/10ps

module tb;
    import sbs_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] cfg_wr_in = 8'h00;
    logic [3:0] cfg_size_in = 4'h0;
    logic cfg_enable_in = 1'b0;
    logic [7:0][31:0] base_in = '0;
    logic [7:0][7:0] bank_count_in;
    logic [7:0][7:0] row_bits;
    logic [7:0][7:0] col_bits;
    logic [7:0][7:0] width;
    logic scrub_enable_in = 1'b0;
    logic [31:0] addr_in = 32'h0000_0000;
    logic [2:0] odd_blk = 3'h7;
    logic [7:0][3:0] size_out;
    logic [7:0] enable_out;
    logic [7:0] scrub_incl_out;
    logic hit_out;
    logic [2:0] hit_block_out;
    logic [31:0] offset_out;
    logic [31:0] row_out;
    logic [31:0] col_out;
    logic [31:0] m;
    logic [31:0] r0;
    logic [31:0] c0;
    logic [3:0] s;
    int fails = 0;
    int comparisons = 0;

    sbs_block_sizing i_dut (.clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in),
        .cfg_size_in(cfg_size_in), .cfg_enable_in(cfg_enable_in), .base_in(base_in),
        .bank_count_in(bank_count_in), .scrub_enable_in(scrub_enable_in), .addr_in(addr_in),
        .size_out(size_out), .enable_out(enable_out), .scrub_incl_out(scrub_incl_out),
        .hit_out(hit_out), .hit_block_out(hit_block_out), .offset_out(offset_out),
        .row_out(row_out), .col_out(col_out));

    sbs_spd_model i_spd (.odd_block_in(odd_blk), .bank_count_out(bank_count_in),
        .row_bits_out(row_bits), .col_bits_out(col_bits), .width_out(width));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        forever #2 clk_in = ~clk_in;
    end

    // Compare one value and count it
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Load size and enable into one block
    task cfg(input int b, input logic [3:0] s, input logic e);
        @(posedge clk_in);
        cfg_wr_in <= 8'h01 << b;
        cfg_size_in <= s;
        cfg_enable_in <= e;
        @(posedge clk_in);
        cfg_wr_in <= 8'h00;
        #1;
    endtask

    // Present an address and wait for its decode
    task probe(input logic [31:0] a);
        @(posedge clk_in);
        addr_in <= a;
        @(posedge clk_in);
        #1;
    endtask

    // Capacity minus one for a size code
    function automatic logic [31:0] mask_of(input logic [3:0] c);
        case (c)
            4'h1: return 32'h01FF_FFFF;
            4'h2, 4'h3: return 32'h03FF_FFFF;
            4'h4, 4'h5, 4'h6: return 32'h07FF_FFFF;
            4'h7, 4'h8: return 32'h0FFF_FFFF;
            default: return 32'h1FFF_FFFF;
        endcase
    endfunction

    // Column width chosen for a size code
    function automatic int col_w(input logic [3:0] c);
        case (c)
            4'h1, 4'h6: return 8;
            4'h2, 4'h3, 4'h4, 4'h5: return 9;
            4'h7, 4'h8: return 10;
            default: return 11;
        endcase
    endfunction

    // Highest address on the probe list of a trial size
    function automatic logic [31:0] list_top(input logic [3:0] c);
        case (c)
            4'h1: return 32'h0000_1000;
            4'h2, 4'h3: return 32'h0000_2000;
            4'h4, 4'h5: return 32'h0000_4000;
            4'h6: return 32'h0400_0000;
            4'h7: return 32'h0000_8000;
            4'h8: return 32'h0800_0000;
            default: return 32'h1000_0000;
        endcase
    endfunction

    // Size code from presence data: location count and primary width
    function automatic logic [3:0] spd_code(input int r, c, k, w);
        int lm;
        lm = ((1 << (r + c)) * k) >> 20;
        case (lm)
            4: return (w == 16) ? 4'h1 : 4'h0;
            8: return (w == 8) ? 4'h2 : (w == 16) ? 4'h3 : 4'h0;
            16: return (w == 4) ? 4'h4 : (w == 8) ? 4'h5 : (w == 16) ? 4'h6 : 4'h0;
            32: return (w == 4) ? 4'h7 : (w == 8) ? 4'h8 : 4'h0;
            64: return (w == 4) ? 4'h9 : 4'h0;
            default: return 4'h0;
        endcase
    endfunction

    // Let a refresh interval pass before the control settings are rewritten
    task refresh_wait;
        repeat (100) @(posedge clk_in);
    endtask

    // Verdict and end of run
    task finish_test;
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #20000;
        fails++;
        finish_test;
    end

    // Test sequence
    initial begin
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        chk(size_out, 32'h0);
        chk(enable_out, 32'h0);
        chk(hit_out, 32'h0);
        // Block 0 alone at base zero, trial sizes from the largest down:
        // probe-list top and last word claimed, next byte not
        for (int c = 9; c >= 1; c--) begin
            m = mask_of(4'(c));
            refresh_wait;
            cfg(0, 4'(c), 1'b1);
            chk(size_out[0], 32'(c));
            probe(list_top(4'(c)));
            chk(hit_out, 32'h1);
            probe(m - 32'h7);
            chk(hit_out, 32'h1);
            chk(offset_out, m - 32'h7);
            chk(col_out, ((m >> 3) & ((32'h1 << col_w(4'(c))) - 32'h1)));
            chk(row_out, (m >> 3) >> col_w(4'(c)));
            probe(m + 32'h1);
            chk(hit_out, 32'h0);
            chk(col_out, 32'h0);
        end
        // Unused codes never claim
        cfg(0, 4'h0, 1'b1);
        probe(32'h0000_0000);
        chk(hit_out, 32'h0);
        cfg(0, 4'hA, 1'b1);
        probe(32'h0000_0000);
        chk(hit_out, 32'h0);
        cfg(0, 4'h0, 1'b0);
        // Aligned base away from zero, then the same block disabled
        @(posedge clk_in);
        base_in[2] <= 32'h2000_0000;
        cfg(2, 4'h9, 1'b1);
        probe(32'h2000_0010);
        chk({hit_out, hit_block_out}, 32'hA);
        chk(offset_out, 32'h10);
        probe(32'h1FFF_FFF8);
        chk(hit_out, 32'h0);
        cfg(2, 4'h9, 1'b0);
        probe(32'h2000_0010);
        chk(hit_out, 32'h0);
        // Unsupported bank count refuses the enable
        @(posedge clk_in);
        odd_blk <= 3'h3;
        cfg(3, 4'h1, 1'b1);
        chk(enable_out[3], 32'h0);
        probe(32'h0000_0100);
        chk(hit_out, 32'h0);
        // Scrub membership follows a non-zero size
        @(posedge clk_in);
        scrub_enable_in <= 1'b1;
        cfg(4, 4'h1, 1'b1);
        chk(scrub_incl_out[5:4], 32'h1);
        cfg(4, 4'h0, 1'b0);
        chk(scrub_incl_out[4], 32'h0);
        // Paired codes decode the same address the same way
        for (int p = 0; p < 2; p++) begin
            cfg(0, p ? 4'h2 : 4'h4, 1'b1);
            probe(32'h0123_4568);
            r0 = row_out;
            c0 = col_out;
            cfg(0, p ? 4'h3 : 4'h5, 1'b1);
            probe(32'h0123_4568);
            chk(hit_out, 32'h1);
            chk(row_out, r0);
            chk(col_out, c0);
        end
        // Sizes taken from presence data, each block alone, then switched off
        for (int b = 0; b < 8; b++) begin
            s = spd_code(row_bits[b], col_bits[b], bank_count_in[b], width[b]);
            m = (32'h1 << (row_bits[b] + col_bits[b] + 8'h05)) - 32'h1;
            cfg(b, s, s != 4'h0);
            probe(base_in[b] + m - 32'h7);
            chk({hit_out, hit_block_out}, (s != 4'h0) ? 32'(8 + b) : 32'h0);
            probe(base_in[b] + m + 32'h1);
            chk(hit_out, 32'h0);
            cfg(b, s, 1'b0);
        end
        // Reset in mid-run clears every size and enable
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        chk(size_out, 32'h0);
        chk(enable_out, 32'h0);
        finish_test;
    end
endmodule
